// *** rtl/dcs_pkg.sv ***
package dcs_pkg;
   // =====================================
   // Switch field positions
   localparam int LSW_RESV_BIT = 7;
   localparam int LSW_IRQ_HI = 6;
   localparam int LSW_IRQ_LO = 5;
   localparam int LSW_SC_HI = 4;
   localparam int LSW_SC_LO = 0;
   localparam int RSW_PROTO_BIT = 0;
   localparam int RSW_PAR_HI = 2;
   localparam int RSW_PAR_LO = 1;
   localparam int RSW_HS_HI = 4;
   localparam int RSW_HS_LO = 3;
   localparam int RSW_BAUD_HI = 7;
   localparam int RSW_BAUD_LO = 5;
   // =====================================
   // Values
   localparam logic [2:0] IRQ_LEVEL_BASE = 3'h3;
   localparam logic [4:0] SC_MIN_VALID = 5'h08;
   localparam logic [4:0] SC_FACTORY = 5'h14;
   localparam logic [1:0] IRQ_SW_FACTORY = 2'h0;
   localparam logic RESV_EXPECTED = 1'b1;
   // =====================================
   // Register map
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_FMT = 4'h1;
   localparam logic [3:0] REG_STAT = 4'h2;
   localparam logic [3:0] REG_SW = 4'h3;
   // REG_CTRL fields
   localparam int CTL_PROTO = 0;
   localparam int CTL_HS_LO = 1;
   localparam int CTL_HS_HI = 2;
   localparam int CTL_DUPLEX = 3;
   // REG_FMT fields
   localparam int FMT_PAR_LO = 0;
   localparam int FMT_PAR_HI = 1;
   localparam int FMT_BAUD_LO = 2;
   localparam int FMT_BAUD_HI = 4;
   localparam int FMT_BPC_LO = 5;
   localparam int FMT_BPC_HI = 6;
   localparam int FMT_STOP = 7;

   typedef enum logic [1:0] {
      HS_OFF_NONMODEM,
      HS_ON_NONMODEM,
      HS_MODEM_HALF,
      HS_MODEM_FULL
   } dcs_hs_e;
   // Bits per character codes: 5,6,7,8
   localparam logic [1:0] BPC_7 = 2'h2;
   localparam logic [1:0] BPC_8 = 2'h3;
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [2:0] BAUD_SLOW_MAX = 3'h1;
endpackage : dcs_pkg

// *** rtl/dcs_switch_decoder.sv ***
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ns
// Behaviour
// - Switch 7 reserved, expected off (1)
// - Switches 6,5 give interrupt level 3-6
// - Five-bit select code; 8..31 valid
// - Factory select code 20 (10100)
// - Factory interrupt level 3
// - Load right cluster at every reset
// - Bit 0 picks async or data link
// - Host may override protocol, rewrites rest
// - Defaults derive format from parity, baud
// - Host sets format fields independently
// - Status returns parameters in effect
// - Async handshake off, on, modem duplex
module dcs_switch_decoder #(
   parameter logic [4:0] SC_DEFAULT = dcs_pkg::SC_FACTORY,
   parameter logic [1:0] IRQ_SW_DEFAULT = dcs_pkg::IRQ_SW_FACTORY
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [7:0] left_sw,
   input wire logic [7:0] right_sw,
   input wire logic [4:0] bp_sel_code,
   input wire logic bp_access,
   input wire logic irq_req,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic bp_selected,
   output logic [6:3] irq_level_out,
   output logic [2:0] irq_level,
   output logic [4:0] sel_code,
   output logic sel_code_ok,
   output logic resv_ok,
   output logic data_link_protocol,
   output logic [1:0] handshake,
   output logic duplex_full,
   output logic [1:0] parity,
   output logic [2:0] baud,
   output logic [1:0] bits_per_char,
   output logic two_stop
);

   // =====================================
   // Switch synchronisers
   logic [7:0] lsw_meta_r;
   logic [7:0] lsw_r;
   logic [7:0] rsw_meta_r;
   logic [7:0] rsw_r;
   logic [4:0] bsc_meta_r;
   logic [4:0] bsc_r;
   logic bac_meta_r;
   logic bac_r;
   logic irq_meta_r;
   logic irq_r;
   logic [1:0] load_cnt_r;
   logic load_done_r;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         lsw_meta_r <= '0;
         lsw_r <= '0;
         rsw_meta_r <= '0;
         rsw_r <= '0;
         bsc_meta_r <= '0;
         bsc_r <= '0;
         bac_meta_r <= 1'b0;
         bac_r <= 1'b0;
         irq_meta_r <= 1'b0;
         irq_r <= 1'b0;
      end else if (ce) begin
         lsw_meta_r <= left_sw;
         lsw_r <= lsw_meta_r;
         rsw_meta_r <= right_sw;
         rsw_r <= rsw_meta_r;
         bsc_meta_r <= bp_sel_code;
         bsc_r <= bsc_meta_r;
         bac_meta_r <= bp_access;
         bac_r <= bac_meta_r;
         irq_meta_r <= irq_req;
         irq_r <= irq_meta_r;
      end
   end

   // Wait for synchroniser to fill before latching the switches
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         load_cnt_r <= 2'h0;
         load_done_r <= 1'b0;
      end else if (ce && !load_done_r) begin
         load_cnt_r <= load_cnt_r + 2'h1;
         if (load_cnt_r == 2'h2) begin
            load_done_r <= 1'b1;
         end
      end
   end

   wire logic load_now = ce && !load_done_r && (load_cnt_r == 2'h2);

   // =====================================
   // Decode helpers
   function automatic logic [2:0] irq_decode(input logic [1:0] sw);
      irq_decode = dcs_pkg::IRQ_LEVEL_BASE + {1'b0, sw};
   endfunction : irq_decode

   // Defaults: 8 bits without parity, else 7; two stops at slow rates
   function automatic logic [1:0] bpc_from(input logic [1:0] par);
      bpc_from = (par == dcs_pkg::PAR_NONE) ? dcs_pkg::BPC_8 : dcs_pkg::BPC_7;
   endfunction : bpc_from

   // =====================================
   // Left cluster, latched once
   logic [1:0] irq_sw_r;
   logic [4:0] sc_r;
   logic resv_r;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         irq_sw_r <= IRQ_SW_DEFAULT;
         sc_r <= SC_DEFAULT;
         resv_r <= dcs_pkg::RESV_EXPECTED;
      end else if (load_now) begin
         irq_sw_r <= lsw_r[dcs_pkg::LSW_IRQ_HI:dcs_pkg::LSW_IRQ_LO];
         sc_r <= lsw_r[dcs_pkg::LSW_SC_HI:dcs_pkg::LSW_SC_LO];
         resv_r <= lsw_r[dcs_pkg::LSW_RESV_BIT];
      end
   end

   // =====================================
   // Operating parameters: switch defaults, then host overrides
   logic proto_r;
   logic [1:0] hs_r;
   logic dup_r;
   logic [1:0] par_r;
   logic [2:0] baud_r;
   logic [1:0] bpc_r;
   logic stop_r;
   logic [1:0] sw_par;
   logic [2:0] sw_baud;

   assign sw_par = rsw_r[dcs_pkg::RSW_PAR_HI:dcs_pkg::RSW_PAR_LO];
   assign sw_baud = rsw_r[dcs_pkg::RSW_BAUD_HI:dcs_pkg::RSW_BAUD_LO];

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         proto_r <= 1'b0;
         hs_r <= dcs_pkg::HS_OFF_NONMODEM;
         dup_r <= 1'b0;
         par_r <= dcs_pkg::PAR_NONE;
         baud_r <= '0;
         bpc_r <= dcs_pkg::BPC_8;
         stop_r <= 1'b0;
      end else if (load_now) begin
         proto_r <= rsw_r[dcs_pkg::RSW_PROTO_BIT];
         hs_r <= rsw_r[dcs_pkg::RSW_HS_HI:dcs_pkg::RSW_HS_LO];
         dup_r <= (rsw_r[dcs_pkg::RSW_HS_HI:dcs_pkg::RSW_HS_LO] == dcs_pkg::HS_MODEM_FULL);
         par_r <= sw_par;
         baud_r <= sw_baud;
         bpc_r <= bpc_from(sw_par);
         stop_r <= (sw_baud <= dcs_pkg::BAUD_SLOW_MAX);
      end else if (ce && load_done_r && reg_wr) begin
         if (reg_addr == dcs_pkg::REG_CTRL) begin
            proto_r <= reg_wdata[dcs_pkg::CTL_PROTO];
            hs_r <= reg_wdata[dcs_pkg::CTL_HS_HI:dcs_pkg::CTL_HS_LO];
            dup_r <= reg_wdata[dcs_pkg::CTL_DUPLEX];
         end
         if (reg_addr == dcs_pkg::REG_FMT) begin
            par_r <= reg_wdata[dcs_pkg::FMT_PAR_HI:dcs_pkg::FMT_PAR_LO];
            baud_r <= reg_wdata[dcs_pkg::FMT_BAUD_HI:dcs_pkg::FMT_BAUD_LO];
            bpc_r <= reg_wdata[dcs_pkg::FMT_BPC_HI:dcs_pkg::FMT_BPC_LO];
            stop_r <= reg_wdata[dcs_pkg::FMT_STOP];
         end
      end
   end

   // =====================================
   // Register read, data one cycle after strobe
   logic [7:0] rdata_nxt;

   always_comb begin
      case (reg_addr)
         dcs_pkg::REG_CTRL: rdata_nxt = {4'h0, dup_r, hs_r, proto_r};
         dcs_pkg::REG_FMT: rdata_nxt = {stop_r, bpc_r, baud_r, par_r};
         dcs_pkg::REG_STAT: rdata_nxt = {load_done_r, resv_r, (sc_r >= dcs_pkg::SC_MIN_VALID),
                                        sc_r};
         dcs_pkg::REG_SW: rdata_nxt = rsw_r;
         default: rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (ce) begin
         reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
      end
   end

   // =====================================
   // Backplane select and interrupt steering
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         bp_selected <= 1'b0;
         irq_level_out <= 4'h0;
      end else if (ce) begin
         // Invalid codes never answer, so a misset card stays off the bus
         bp_selected <= load_done_r && bac_r && (bsc_r == sc_r)
                        && (sc_r >= dcs_pkg::SC_MIN_VALID);
         irq_level_out <= (load_done_r && irq_r) ? (4'h1 << irq_sw_r) : 4'h0;
      end
   end

   // =====================================
   // Registered status outputs
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         irq_level <= dcs_pkg::IRQ_LEVEL_BASE;
         sel_code <= '0;
         sel_code_ok <= 1'b0;
         resv_ok <= 1'b0;
         data_link_protocol <= 1'b0;
         handshake <= '0;
         duplex_full <= 1'b0;
         parity <= '0;
         baud <= '0;
         bits_per_char <= '0;
         two_stop <= 1'b0;
      end else if (ce) begin
         irq_level <= irq_decode(irq_sw_r);
         sel_code <= sc_r;
         sel_code_ok <= sc_r >= dcs_pkg::SC_MIN_VALID;
         resv_ok <= resv_r == dcs_pkg::RESV_EXPECTED;
         data_link_protocol <= proto_r;
         handshake <= hs_r;
         duplex_full <= dup_r;
         parity <= par_r;
         baud <= baud_r;
         bits_per_char <= bpc_r;
         two_stop <= stop_r;
      end
   end

endmodule : dcs_switch_decoder

// *** verification/dcs_switch_decoder_assertions.sv ***
`timescale 1ns/1ns
module dcs_chk (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_rdata,
   input wire logic bp_access,
   input wire logic [4:0] bp_sel_code,
   input wire logic bp_selected,
   input wire logic [6:3] irq_level_out,
   input wire logic [2:0] irq_level,
   input wire logic [4:0] sel_code,
   input wire logic sel_code_ok,
   input wire logic resv_ok,
   input wire logic [1:0] bits_per_char,
   input wire logic two_stop
);
   // =====================================
   // Edges since reset release, saturating
   logic [3:0] up_r;
   always_ff @(posedge clk_sys) begin
      if (!rstn) up_r <= 4'h0;
      else if (up_r != 4'hF) up_r <= up_r + 4'h1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not idle");
   chk_lvl_range: assert property (irq_level >= 3'h3 && irq_level <= 3'h6)
      else $error("level out of range");
   chk_sc_valid: assert property (sel_code_ok == (sel_code >= 5'h08))
      else $error("select code flag wrong");
   chk_sel_match: assert property ((bp_access && bp_sel_code == sel_code && sel_code_ok)[*5] |-> bp_selected)
      else $error("access not selected");
   chk_sel_drop: assert property ((!bp_access)[*5] |-> !bp_selected)
      else $error("selected without access");
   chk_irq_line: assert property (irq_level_out != 4'h0 |-> irq_level_out == (4'h1 << (irq_level - 3'h3)))
      else $error("interrupt on wrong level");
   chk_latch_hold: assert property (up_r >= 4'h6 |-> $stable(sel_code) && $stable(irq_level) && $stable(resv_ok))
      else $error("latched switch value moved");
   chk_fmt_hold: assert property (up_r >= 4'h6 && !$past(reg_wr) && !$past(reg_wr, 2) && !$past(reg_wr, 3)
      |-> $stable(bits_per_char) && $stable(two_stop))
      else $error("format moved without write");
endmodule : dcs_chk
bind dcs_switch_decoder dcs_chk u_chk (.clk_sys, .rstn, .reg_rd, .reg_wr, .reg_rdata, .bp_access, .bp_sel_code,
   .bp_selected, .irq_level_out, .irq_level, .sel_code, .sel_code_ok, .resv_ok, .bits_per_char, .two_stop);

// *** verification/dcs_host_model.sv ***
`timescale 1ns/1ns
module dcs_host_model (
   input wire logic clk_sys,
   input wire logic go,
   input wire logic [4:0] code,
   input wire logic [6:3] irq_level_out,
   output logic bp_access,
   output logic [4:0] bp_sel_code,
   output logic [2:0] served
);
   initial begin
      bp_access = 1'b0;
      bp_sel_code = 5'h00;
   end
   // One code per access; idle bus toggles so a stale code never lingers
   always @(posedge clk_sys) begin
      bp_access <= go;
      bp_sel_code <= go ? code : ~bp_sel_code;
   end
   // Highest pending level wins
   always_comb begin
      served = 3'h0;
      for (int k = 3; k <= 6; k++) if (irq_level_out[k]) served = 3'(k);
   end
endmodule : dcs_host_model

// *** verification/tb_dcs_switch_decoder.sv ***
`timescale 1ns/1ns
module tb_dcs_switch_decoder;
   logic clk_sys = 0, rstn = 0, reg_wr = 0, reg_rd = 0, irq_req = 0, go = 0;
   logic [7:0] left_sw = 8'h00, right_sw = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
   logic [3:0] reg_addr = 4'h0;
   logic [4:0] code = 5'h00, bp_sel_code, sel_code;
   logic bp_access, bp_selected, sel_code_ok, resv_ok, data_link_protocol, duplex_full, two_stop;
   logic [6:3] irq_level_out;
   logic [2:0] irq_level, baud, served;
   logic [1:0] handshake, parity, bits_per_char;
   int err_total = 0, tests_run = 0, i;
   // {left, right, level, bpc code, two stop}
   logic [21:0] rows [4] = '{{8'h67, 8'h54, 3'h6, 2'h2, 1'b0}, {8'h88, 8'hFF, 3'h3, 2'h2, 1'b0},
      {8'hDF, 8'h2A, 3'h5, 2'h2, 1'b1}, {8'hB4, 8'h00, 3'h4, 2'h3, 1'b1}};
   dcs_switch_decoder dut (.clk_sys, .rstn, .ce(1'b1), .left_sw, .right_sw, .bp_sel_code, .bp_access, .irq_req,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bp_selected, .irq_level_out, .irq_level, .sel_code,
      .sel_code_ok, .resv_ok, .data_link_protocol, .handshake, .duplex_full, .parity, .baud, .bits_per_char, .two_stop);
   dcs_host_model host (.clk_sys, .go, .code, .irq_level_out, .bp_access, .bp_sel_code, .served);
   initial forever #5 clk_sys = ~clk_sys;
   // =====================================
   // Tasks
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task stop_test;
      $display("%0d checks, %0d wrong", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   task load(input logic [7:0] l, input logic [7:0] r);
      @(posedge clk_sys);
      rstn <= 1'b0;
      left_sw <= l;
      right_sw <= r;
      repeat (5) @(posedge clk_sys);
      chk(8'(irq_level), 8'h03);
      chk(8'(sel_code), 8'h00);
      rstn <= 1'b1;
      repeat (7) @(posedge clk_sys);
   endtask : load
   task wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   // =====================================
   // Sequence
   initial begin
      for (i = 0; i < 4; i++) begin
         load(rows[i][21:14], rows[i][13:6]);
         chk(8'(irq_level), 8'(rows[i][5:3]));
         chk(8'(sel_code), 8'(rows[i][18:14]));
         chk(8'(sel_code_ok), 8'(rows[i][18:14] >= 5'h08));
         chk(8'(resv_ok), 8'(rows[i][21]));
         chk(8'(data_link_protocol), 8'(rows[i][6]));
         chk({handshake, parity, baud, duplex_full}, {rows[i][10:9], rows[i][8:7], rows[i][13:11], &rows[i][10:9]});
         chk(8'({bits_per_char, two_stop}), 8'(rows[i][2:0]));
         $display("row %0d done", i);
      end
      left_sw <= 8'h88;
      right_sw <= 8'hFF;
      repeat (8) @(posedge clk_sys);
      chk(8'(sel_code), 8'h14);
      chk(8'(data_link_protocol), 8'h00);
      wr(dcs_pkg::REG_CTRL, 8'h0D);
      wr(dcs_pkg::REG_FMT, 8'h9C);
      repeat (3) @(posedge clk_sys);
      chk(8'({data_link_protocol, handshake, duplex_full}), 8'h0D);
      chk({bits_per_char, two_stop, baud, parity}, 8'h3C);
      rd(dcs_pkg::REG_FMT);
      chk(d, 8'h9C);
      rd(dcs_pkg::REG_CTRL);
      chk(d, 8'h0D);
      rd(dcs_pkg::REG_SW);
      chk(d, 8'hFF);
      wr(dcs_pkg::REG_STAT, 8'h00);
      rd(dcs_pkg::REG_STAT);
      chk(d, 8'hF4);
      rd(4'hF);
      chk(d, 8'h00);
      $display("override done");
      code <= 5'h14;
      go <= 1'b1;
      for (i = 0; i < 8 && bp_selected !== 1'b1; i++) @(posedge clk_sys);
      if (i == 8) begin
         err_total++;
         stop_test;
      end
      chk(8'(bp_selected), 8'h01);
      code <= 5'h15;
      irq_req <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk(8'(bp_selected), 8'h00);
      chk(8'(irq_level_out), 8'h02);
      chk(8'(served), 8'h04);
      go <= 1'b0;
      irq_req <= 1'b0;
      $display("backplane done");
      // Unusable code must never answer, even when addressed exactly
      load(8'h67, 8'h54);
      code <= 5'h07;
      go <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk(8'(bp_selected), 8'h00);
      go <= 1'b0;
      $display("invalid code done");
      stop_test;
   end
endmodule : tb_dcs_switch_decoder
